// file: hdl/usc_top.sv
`timescale 1ns/1ps
module usc_top (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [usc_pkg::USC_AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic data_bit_i,
  input wire logic ctrl_bit_i,
  input wire logic bit_valid_i,
  output logic bit_ready_o,
  output logic [usc_pkg::USC_CHIP_W-1:0] chip_re_o,
  output logic [usc_pkg::USC_CHIP_W-1:0] chip_im_o,
  output logic chip_valid_o
);
  import usc_pkg::*;

  usc_top_t st_r;
  usc_top_t st_nxt;
  logic acc_wr;
  logic acc_rd;
  logic start_go;
  logic stop_go;
  logic adv;
  logic take_bits;
  logic last_chip;
  logic [7:0] sf_mask;
  logic [3:0] sf_eff;
  logic d_code_neg;
  logic c_code_neg;
  logic scr_re_neg;
  logic scr_im_neg;
  logic i_neg;
  logic q_neg;
  logic [5:0] q_amp;
  logic [31:0] wmask;
  logic bus_req;
  logic running;
  logic sf_over;
  logic re_i_neg;
  logic re_q_neg;
  logic im_i_neg;
  logic im_q_neg;
  logic [5:0] re_val;
  logic [5:0] im_val;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [5:0] sgn(input logic neg, input logic [5:0] m);
    sgn = neg ? 6'(-m) : m;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [31:0] msk);
    merge = (old & ~msk) | (wd & msk);
  endfunction

  // status word: run flag, symbol held, chip index
  function automatic logic [31:0] status_of(input logic run,
                                            input logic sym,
                                            input logic [7:0] idx);
    status_of = 32'h00000000;
    status_of[USC_ST_RUN_BIT] = run;
    status_of[USC_ST_SYM_BIT] = sym;
    status_of[USC_ST_IDX_LSB +: 8] = idx;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus access decode

  // a write lands on the edge where waitrequest is low; a read is decoded one edge earlier, while it is high
  assign acc_wr = avs_write_i && !st_r.wait_req;
  assign acc_rd = avs_read_i && st_r.wait_req;
  assign bus_req = avs_read_i || avs_write_i;
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wmask[8*b +: 8] = {8{avs_byteenable_i[b]}};
  end
  assign start_go = acc_wr && (avs_address_i == USC_OFS_CTRL) &&
                    avs_byteenable_i[0] &&
                    avs_writedata_i[USC_CTRL_START_BIT];
  assign stop_go = acc_wr && (avs_address_i == USC_OFS_CTRL) &&
                   avs_byteenable_i[0] &&
                   avs_writedata_i[USC_CTRL_STOP_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // channelization and scrambling codes

  // spreading factors above the top of the code tree clamp to it
  assign sf_over = (st_r.sf_log2 > USC_SF_LOG2_MAX);
  assign sf_eff = sf_over ? USC_SF_LOG2_MAX : st_r.sf_log2;
  assign sf_mask = 8'((9'h001 << sf_eff) - 9'h001);
  assign last_chip = (st_r.chip_idx == sf_mask);

  ////////////////////////////////////////////////////////////////////////////
  // symbol handshake and chip pacing
  assign running = (st_r.state == USC_RUN);
  assign adv = running && st_r.have_sym;
  assign take_bits = running && st_r.ready && bit_valid_i;

  usc_orthogonal_variable_code u_data_code (
    .sf_log2_i(sf_eff),
    .code_i(st_r.dcode & sf_mask),
    .idx_i(st_r.chip_idx),
    .neg_o(d_code_neg)
  );

  usc_orthogonal_variable_code u_ctrl_code (
    .sf_log2_i(sf_eff),
    .code_i(st_r.ccode & sf_mask),
    .idx_i(st_r.chip_idx),
    .neg_o(c_code_neg)
  );

  usc_scr u_scr (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .load_i(start_go),
    .code_i(st_r.scode),
    .adv_i(adv),
    .re_neg_o(scr_re_neg),
    .im_neg_o(scr_im_neg)
  );

  ////////////////////////////////////////////////////////////////////////////
  // spreading and complex scrambling

  // symbol bit 1 is -1, code bit 1 is -1: product is the xor
  assign i_neg = st_r.dsym ^ d_code_neg;
  assign q_neg = st_r.csym ^ c_code_neg;
  // gain setting n gives amplitude n against 15 on the data branch
  assign q_amp = {2'b00, st_r.gain};

  ////////////////////////////////////////////////////////////////////////////
  // complex product (I + jQ)(Sr + jSi), signs as xor

  assign re_i_neg = i_neg ^ scr_re_neg;
  assign re_q_neg = q_neg ^ scr_im_neg;
  assign im_i_neg = i_neg ^ scr_im_neg;
  assign im_q_neg = q_neg ^ scr_re_neg;
  // real part takes -Q*Si, imaginary part +Q*Sr
  assign re_val = 6'(sgn(re_i_neg, USC_DATA_AMP) - sgn(re_q_neg, q_amp));
  assign im_val = 6'(sgn(im_i_neg, USC_DATA_AMP) + sgn(im_q_neg, q_amp));

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_nxt = st_r;
    st_nxt.chip_valid = 1'b0;
    // one wait cycle per access, then release
    if (st_r.wait_req) begin
      st_nxt.wait_req = !bus_req;
    end else begin
      st_nxt.wait_req = 1'b1;
    end
    // register reads
    if (acc_rd) begin
      case (avs_address_i)
        USC_OFS_SF: begin
          st_nxt.rdata = {28'h0000000, st_r.sf_log2};
        end
        USC_OFS_DCODE: begin
          st_nxt.rdata = {24'h000000, st_r.dcode};
        end
        USC_OFS_CCODE: begin
          st_nxt.rdata = {24'h000000, st_r.ccode};
        end
        USC_OFS_GAIN: begin
          st_nxt.rdata = {28'h0000000, st_r.gain};
        end
        USC_OFS_SCODE: begin
          st_nxt.rdata = {8'h00, st_r.scode};
        end
        USC_OFS_STATUS: begin
          st_nxt.rdata = status_of(running, st_r.have_sym, st_r.chip_idx);
        end
        default: begin
          st_nxt.rdata = 32'h00000000;
        end
      endcase
    end
    // register writes
    if (acc_wr) begin
      case (avs_address_i)
        USC_OFS_SF: begin
          st_nxt.sf_log2 = 4'(merge(32'(st_r.sf_log2), avs_writedata_i,
                                    wmask));
        end
        USC_OFS_DCODE: begin
          st_nxt.dcode = 8'(merge(32'(st_r.dcode), avs_writedata_i,
                                  wmask));
        end
        USC_OFS_CCODE: begin
          st_nxt.ccode = 8'(merge(32'(st_r.ccode), avs_writedata_i,
                                  wmask));
        end
        USC_OFS_GAIN: begin
          st_nxt.gain = 4'(merge(32'(st_r.gain), avs_writedata_i,
                                 wmask));
        end
        USC_OFS_SCODE: begin
          st_nxt.scode = 24'(merge(32'(st_r.scode), avs_writedata_i,
                                   wmask));
        end
        default: begin
        end
      endcase
    end
    // chip generation
    if (adv) begin
      st_nxt.chip_re = re_val;
      st_nxt.chip_im = im_val;
      st_nxt.chip_valid = 1'b1;
      if (last_chip) begin
        st_nxt.have_sym = 1'b0;
        st_nxt.chip_idx = 8'h00;
      end else begin
        st_nxt.chip_idx = 8'(st_r.chip_idx + 8'h01);
      end
    end
    // a new symbol restarts the code word at its first chip
    if (take_bits) begin
      st_nxt.have_sym = 1'b1;
      st_nxt.dsym = data_bit_i;
      st_nxt.csym = ctrl_bit_i;
      st_nxt.chip_idx = 8'h00;
    end
    case (st_r.state)
      USC_IDLE: begin
        if (start_go) begin
          st_nxt.state = USC_RUN;
        end
      end
      USC_RUN: begin
        if (stop_go) begin
          st_nxt.state = USC_IDLE;
        end
      end
      default: begin
        st_nxt.state = USC_IDLE;
      end
    endcase
    // start or stop drops any held symbol
    if (start_go || stop_go) begin
      st_nxt.have_sym = 1'b0;
      st_nxt.chip_idx = 8'h00;
      st_nxt.chip_valid = 1'b0;
    end
    st_nxt.ready = (st_nxt.state == USC_RUN) && !st_nxt.have_sym;
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
      st_r.state <= USC_IDLE;
      st_r.wait_req <= 1'b1;
      st_r.sf_log2 <= USC_SF_RST;
      st_r.dcode <= USC_DCODE_RST;
      st_r.ccode <= USC_CCODE_RST;
      st_r.gain <= USC_GAIN_RST;
      st_r.scode <= USC_SCODE_RST;
      st_r.rdata <= 32'h00000000;
      st_r.ready <= 1'b0;
      st_r.chip_valid <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign avs_readdata_o = st_r.rdata;
  assign avs_waitrequest_o = st_r.wait_req;
  assign bit_ready_o = st_r.ready;
  assign chip_re_o = st_r.chip_re;
  assign chip_im_o = st_r.chip_im;
  assign chip_valid_o = st_r.chip_valid;

endmodule

// file: hdl/usc_pkg.sv
package usc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map (byte addresses)
  localparam int USC_AW = 5;
  localparam logic [4:0] USC_OFS_CTRL = 5'h00;
  localparam logic [4:0] USC_OFS_SF = 5'h04;
  localparam logic [4:0] USC_OFS_DCODE = 5'h08;
  localparam logic [4:0] USC_OFS_CCODE = 5'h0c;
  localparam logic [4:0] USC_OFS_GAIN = 5'h10;
  localparam logic [4:0] USC_OFS_SCODE = 5'h14;
  localparam logic [4:0] USC_OFS_STATUS = 5'h18;

  // control register bits
  localparam int USC_CTRL_START_BIT = 0;
  localparam int USC_CTRL_STOP_BIT = 1;

  // status register bit positions
  localparam int USC_ST_RUN_BIT = 0;
  localparam int USC_ST_SYM_BIT = 1;
  localparam int USC_ST_IDX_LSB = 8;

  // field widths
  localparam int USC_SF_W = 4;
  localparam int USC_CODE_W = 8;
  localparam int USC_GAIN_W = 4;
  localparam int USC_SCODE_W = 24;
  localparam int USC_CHIP_W = 6;

  // reset values, and the largest spreading factor (log2)
  localparam logic [3:0] USC_SF_RST = 4'h8;
  localparam logic [7:0] USC_DCODE_RST = 8'h00;
  localparam logic [7:0] USC_CCODE_RST = 8'h01;
  localparam logic [3:0] USC_GAIN_RST = 4'hf;
  localparam logic [23:0] USC_SCODE_RST = 24'h000000;
  localparam logic [3:0] USC_SF_LOG2_MAX = 4'h8;

  // data branch amplitude; the control branch uses gain/15 of it
  localparam logic [5:0] USC_DATA_AMP = 6'h0f;

  ////////////////////////////////////////////////////////////////////////////
  // scrambling generator
  localparam int USC_LFSR_W = 25;
  localparam int USC_X_FB_TAP = 3;
  localparam int USC_Y_FB_TAP1 = 1;
  localparam int USC_Y_FB_TAP2 = 2;
  localparam int USC_Y_FB_TAP3 = 3;
  // tap set giving the in-phase code advanced by 16,777,232 chips
  localparam int USC_XQ_TAP0 = 4;
  localparam int USC_XQ_TAP1 = 7;
  localparam int USC_XQ_TAP2 = 18;
  localparam int USC_YQ_TAP0 = 4;
  localparam int USC_YQ_TAP1 = 6;
  localparam int USC_YQ_TAP2 = 17;
  localparam logic [24:0] USC_Y_INIT = 25'h1ffffff;

  ////////////////////////////////////////////////////////////////////////////
  // state types
  typedef enum logic [0:0] {
    USC_IDLE = 1'b0,
    USC_RUN = 1'b1
  } usc_state_t;

  typedef struct packed {
    logic [24:0] x;
    logic [24:0] y;
    logic c2_hold;
    logic odd;
  } usc_scr_t;

  typedef struct packed {
    usc_state_t state;
    logic wait_req;
    logic [31:0] rdata;
    logic [3:0] sf_log2;
    logic [7:0] dcode;
    logic [7:0] ccode;
    logic [3:0] gain;
    logic [23:0] scode;
    logic have_sym;
    logic dsym;
    logic csym;
    logic [7:0] chip_idx;
    logic ready;
    logic [5:0] chip_re;
    logic [5:0] chip_im;
    logic chip_valid;
  } usc_top_t;

endpackage

// file: hdl/usc_orthogonal_variable_code.sv
`timescale 1ns/1ps
module usc_orthogonal_variable_code (
  input wire logic [3:0] sf_log2_i,
  input wire logic [7:0] code_i,
  input wire logic [7:0] idx_i,
  output logic neg_o
);
  import usc_pkg::*;

  // code bit b pairs with chip index bit (n-1-b): one tree level per pair
  always_comb begin
    neg_o = 1'b0;
    for (int b = 0; b < 8; b++) begin
      if (b < int'(sf_log2_i)) begin
        neg_o = neg_o ^ (code_i[b] & idx_i[int'(sf_log2_i) - 1 - b]);
      end
    end
  end

endmodule

// file: hdl/usc_scr.sv
`timescale 1ns/1ps
module usc_scr (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [23:0] code_i,
  input wire logic adv_i,
  output logic re_neg_o,
  output logic im_neg_o
);
  import usc_pkg::*;

  usc_scr_t st_r;
  usc_scr_t st_nxt;
  logic c1;
  logic c2;
  logic c2_dec;

  // gold codes: sum of the two m-sequences
  assign c1 = st_r.x[0] ^ st_r.y[0];
  assign c2 = st_r.x[USC_XQ_TAP0] ^ st_r.x[USC_XQ_TAP1] ^
              st_r.x[USC_XQ_TAP2] ^ st_r.y[USC_YQ_TAP0] ^
              st_r.y[USC_YQ_TAP1] ^ st_r.y[USC_YQ_TAP2];
  assign c2_dec = st_r.odd ? st_r.c2_hold : c2;
  // bit 1 means -1; w0 is all +1, w1 is -1 on odd chips
  assign re_neg_o = c1;
  assign im_neg_o = c1 ^ c2_dec ^ st_r.odd;

  always_comb begin
    st_nxt = st_r;
    if (load_i) begin
      st_nxt.x = {1'b1, code_i};
      st_nxt.y = USC_Y_INIT;
      st_nxt.odd = 1'b0;
      st_nxt.c2_hold = 1'b0;
    end else if (adv_i) begin
      // free running: no restart inside the burst
      st_nxt.x = {st_r.x[0] ^ st_r.x[USC_X_FB_TAP],
                  st_r.x[24:1]};
      st_nxt.y = {st_r.y[0] ^ st_r.y[USC_Y_FB_TAP1] ^
                  st_r.y[USC_Y_FB_TAP2] ^ st_r.y[USC_Y_FB_TAP3],
                  st_r.y[24:1]};
      st_nxt.odd = ~st_r.odd;
      if (!st_r.odd) begin
        st_nxt.c2_hold = c2;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

// file: test/usc_assertions.sv
`timescale 1ns/1ps
module usc_checker (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [usc_pkg::USC_AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic bit_valid_i,
  input wire logic bit_ready_o,
  input wire logic [usc_pkg::USC_CHIP_W-1:0] chip_re_o,
  input wire logic [usc_pkg::USC_CHIP_W-1:0] chip_im_o,
  input wire logic chip_valid_o
);
  import usc_pkg::*;
  logic [9:0] run_r;
  logic [9:0] run_nxt;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  function automatic logic [7:0] absv(input logic [5:0] v);
    return v[5] ? {2'h0, -v} : {2'h0, v};
  endfunction
  ////////////////////////////////////////////////////////////
  // chips seen since the last symbol take
  always_comb begin
    run_nxt = run_r;
    if (bit_valid_i && bit_ready_o) begin
      run_nxt = 10'h000;
    end else if (chip_valid_o) begin
      run_nxt = run_r + 10'h001;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      run_r <= 10'h000;
    end else begin
      run_r <= run_nxt;
    end
  end
  ////////////////////////////////////////////////////////////
  property p_take_drop;
    bit_valid_i && bit_ready_o |=> !bit_ready_o;
  endproperty
  a_take_drop: assert property (p_take_drop)
    else $error("ready held after take");
  property p_first_chip;
    bit_valid_i && bit_ready_o |-> ##[1:2] chip_valid_o;
  endproperty
  a_first_chip: assert property (p_first_chip)
    else $error("no chip after take");
  property p_chip_held;
    bit_ready_o |=> !chip_valid_o;
  endproperty
  a_chip_held: assert property (p_chip_held)
    else $error("chip right after ready");
  property p_chip_mag;
    chip_valid_o |-> absv(chip_re_o) + absv(chip_im_o) == 8'h1e;
  endproperty
  a_chip_mag: assert property (p_chip_mag)
    else $error("chip magnitude wrong");
  property p_run_max;
    run_r <= 10'h100;
  endproperty
  a_run_max: assert property (p_run_max)
    else $error("too many chips per symbol");
  property p_wait_ans;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_wait_ans: assert property (p_wait_ans)
    else $error("no bus answer");
  property p_wait_one;
    !avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("answer longer than one cycle");
  property p_unmapped;
    avs_read_i && avs_waitrequest_o && avs_address_i == 5'h1c
      |=> avs_readdata_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
endmodule
bind usc_top usc_checker u_chk (.core_clk_i, .rst_n_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o,
  .bit_valid_i, .bit_ready_o, .chip_re_o, .chip_im_o, .chip_valid_o);

// file: test/usc_partner.sv
`timescale 1ns/1ps
module usc_partner (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [9:0] quota_i,
  input wire logic bit_ready_i,
  output logic data_bit_o,
  output logic ctrl_bit_o,
  output logic bit_valid_o
);
  logic [9:0] cnt;
  logic lag;
  // coder holds a pair until taken, stops at quota, sometimes lags
  always @(posedge core_clk_i) begin
    lag <= rst_n_i & ~lag;
    if (!rst_n_i) begin
      cnt <= 10'h000;
      bit_valid_o <= 1'b0;
      data_bit_o <= 1'b0;
      ctrl_bit_o <= 1'b1;
    end else if (bit_valid_o && bit_ready_i) begin
      cnt <= cnt + 10'h001;
      bit_valid_o <= 1'b0;
      data_bit_o <= ~data_bit_o;
      ctrl_bit_o <= ~ctrl_bit_o;
    end else if (!bit_valid_o && cnt < quota_i && (lag || !cnt[1])) begin
      bit_valid_o <= 1'b1;
      data_bit_o <= cnt[0] ^ cnt[2];
      ctrl_bit_o <= cnt[1];
    end
  end
endmodule

// file: test/tb_uplink_spread_scramble.sv
`timescale 1ns/1ps
module tb_uplink_spread_scramble;
  import usc_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [USC_AW-1:0] avs_address_i = '0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = '0;
  logic [31:0] avs_readdata_o, q;
  logic avs_waitrequest_o, data_bit_i, ctrl_bit_i, bit_valid_i;
  logic bit_ready_o, chip_valid_o, sd, sc, c2h;
  logic [USC_CHIP_W-1:0] chip_re_o, chip_im_o;
  logic [9:0] quota = '0;
  logic [7:0] m_d, m_c;
  logic [24:0] x, y;
  int fail_count = 0;
  int total_checks = 0;
  int chips, chip_n, ci, m_g, sf_n;
  always #10 core_clk_i = ~core_clk_i;
  usc_top dut (.core_clk_i, .rst_n_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i(4'hf),
    .avs_readdata_o, .avs_waitrequest_o, .data_bit_i, .ctrl_bit_i,
    .bit_valid_i, .bit_ready_o, .chip_re_o, .chip_im_o, .chip_valid_o);
  usc_partner u_src (.core_clk_i, .rst_n_i, .quota_i(quota),
    .bit_ready_i(bit_ready_o), .data_bit_o(data_bit_i),
    .ctrl_bit_o(ctrl_bit_i), .bit_valid_o(bit_valid_i));
  ////////////////////////////////////////////////////////////
  function automatic logic orthogonal_variable_code(input logic [7:0] k, input int i);
    logic p;
    p = 1'b0;
    for (int b = 0; b < sf_n; b++) begin
      p ^= k[b] & i[sf_n-1-b];
    end
    return p;
  endfunction
  task automatic judge(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= d;
    do begin
      @(posedge core_clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // reference chip model, fed by what the ports show
  always @(posedge core_clk_i) begin
    if (chip_valid_o && rst_n_i) begin
      int iv, qv, sr, si, er, ei;
      if (!chip_n[0]) c2h = x[4]^x[7]^x[18]^y[4]^y[6]^y[17];
      iv = (sd ^ orthogonal_variable_code(m_d, ci)) ? -1 : 1;
      qv = (sc ^ orthogonal_variable_code(m_c, ci)) ? -1 : 1;
      sr = (x[0] ^ y[0]) ? -1 : 1;
      si = (c2h ^ chip_n[0]) ? -sr : sr;
      er = 15 * iv * sr - m_g * qv * si;
      ei = 15 * iv * si + m_g * qv * sr;
      judge({20'h0, chip_re_o, chip_im_o}, {20'h0, 6'(er), 6'(ei)});
      x = {x[3] ^ x[0], x[24:1]};
      y = {y[3] ^ y[2] ^ y[1] ^ y[0], y[24:1]};
      chip_n++;
      ci++;
      chips++;
    end
    // a take on the edge of a symbol's last chip applies after it
    if (bit_valid_i && bit_ready_o) begin
      sd = data_bit_i;
      sc = ctrl_bit_i;
      ci = 0;
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic regs();
    logic [31:0] rv [8] = '{0, 32'h8, 0, 32'h1, 32'hf, 0, 0, 0};
    for (int i = 1; i < 8; i++) begin
      bus(1'b0, 5'(4 * i), 32'h0);
      judge(q, rv[i]);
    end
    bus(1'b1, 5'h1c, 32'hffffffff);
    bus(1'b0, 5'h1c, 32'h0);
    judge(q, 32'h0);
    bus(1'b1, USC_OFS_SCODE, 32'hffffffff);
    bus(1'b0, USC_OFS_SCODE, 32'h0);
    judge(q, 32'h00ffffff);
  endtask
  task automatic burst(input int n, input logic [7:0] d, input logic [7:0] c,
                       input int g, input logic [23:0] s, input int ns);
    int k;
    bus(1'b1, USC_OFS_SF, 32'(n));
    bus(1'b1, USC_OFS_DCODE, {24'h0, d});
    bus(1'b1, USC_OFS_CCODE, {24'h0, c});
    bus(1'b1, USC_OFS_GAIN, 32'(g));
    bus(1'b1, USC_OFS_SCODE, {8'h0, s});
    sf_n = n;
    m_d = d;
    m_c = c;
    m_g = g;
    chips = 0;
    chip_n = 0;
    x = {1'b1, s};
    y = USC_Y_INIT;
    bus(1'b1, USC_OFS_CTRL, 32'h1);
    quota <= quota + 10'(ns);
    k = 0;
    while (chips < (ns << n) && k < 2000) begin
      @(posedge core_clk_i);
      k++;
    end
    repeat (4) @(posedge core_clk_i);
    judge(chips, ns << n);
    bus(1'b1, USC_OFS_CTRL, 32'h2);
  endtask
  initial begin
    repeat (8) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    regs();
    for (int g = 0; g < 16; g++) begin
      burst(2, 8'h1, 8'h2, g, 24'h5a3c00 + 24'(g), 2);
    end
    burst(0, 8'h0, 8'h0, 7, 24'h000001, 20);
    burst(8, 8'ha5, 8'h5a, 9, 24'hc3a5f1, 3);
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge core_clk_i);
    fail_count++;
    complete_run();
  end
endmodule
